/* logic/uhpbs_pkg.sv */
// Constants of the host pipe bank status block: register map, field layout,
// event bit positions and reset values.
// Assumes a 32-bit classic Wishbone slave with byte addresses.
package uhpbs_pkg;

  // ==========================================================================
  // Register offsets (byte addresses)
  localparam logic [7:0] OFS_STATUS = 8'h00;
  localparam logic [7:0] OFS_MASK = 8'h04;
  localparam logic [7:0] OFS_DISABLE = 8'h08;
  localparam logic [7:0] OFS_CONFIG = 8'h0C;

  // ==========================================================================
  // Status register fields
  localparam int ACCESS_BIT = 16;
  localparam int CUR_BANK_LSB = 14;
  localparam int BUSY_LSB = 12;
  localparam int TOGGLE_LSB = 8;

  // ==========================================================================
  // Event bits, shared by status, mask and disable registers
  localparam int EV_IN_RX = 0;
  localparam int EV_OUT_TX = 1;
  localparam int EV_UNDER = 2;
  localparam int EV_PERR = 3;
  localparam int EV_NAK = 4;
  localparam int EV_OVER = 5;
  localparam int EV_STALL = 6;
  localparam int EV_BUSY = 7;
  localparam int EV_W = 8;

  // ==========================================================================
  // Config register fields
  localparam int CFG_DIR_BIT = 0;
  localparam int CFG_NBANK_LSB = 4;

  // ==========================================================================
  // Codes and reset values
  localparam logic [1:0] BANK_RSVD = 2'h3;
  localparam logic [1:0] TOG_DATA0 = 2'h0;
  localparam logic [7:0] MASK_RST = 8'h00;
  localparam logic [1:0] NBANK_RST = 2'h3;
  localparam logic [31:0] RD_ZERO = 32'h0000_0000;

endpackage

/* logic/uhpbs_top.sv */
// Bank status, data toggle and interrupt mask logic of one host pipe.
// Assumes pipe events arrive as one-cycle pulses from logic on clk_i, and
// software reaches the registers over a classic Wishbone slave port.

module uhpbs_top #(
  parameter int MAX_BANKS = 3
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic sw_bank_done_i,
  input wire logic usb_bank_done_i,
  input wire logic rx_toggle_i,
  input wire logic rx_stall_i,
  input wire logic overflow_i,
  input wire logic naked_i,
  input wire logic pipe_err_i,
  input wire logic underflow_i,
  output logic pipe_interrupt_line_o,
  output logic bank_access_allowed_o,
  output logic [1:0] current_bank_index_o,
  output logic [1:0] busy_bank_count_o,
  output logic [1:0] data_toggle_field_o
);

  // ==========================================================================
  // Parameter check
  if (MAX_BANKS < 1 || MAX_BANKS > 3)
  begin : g_bad_banks
    $error("MAX_BANKS must lie between 1 and 3");
  end

  localparam logic [1:0] MAXB = 2'(MAX_BANKS);

  // ==========================================================================
  // State
  typedef struct packed {
    logic ack;
    logic [31:0] dat;
    logic [7:0] status;
    logic [7:0] mask;
    logic dir_in;
    logic [1:0] nbank;
    logic [1:0] busy;
    logic [1:0] sw_ptr;
    logic [1:0] usb_ptr;
    logic [1:0] cur_bank;
    logic out_tog;
    logic [2:0] bank_tog;
    logic [1:0] toggle;
    logic acc_ok;
    logic irq;
  } uhpbs_state_t;

  uhpbs_state_t s;
  uhpbs_state_t next_s;

  logic hit;
  logic wr;
  logic [31:0] wdat;
  logic cfg_wr;
  logic dis_wr;
  logic sw_ok;
  logic us_ok;
  logic fill;
  logic drain;
  logic [7:0] ev_set;
  logic [7:0] ev_clr;

  // ==========================================================================
  // Helpers
  // Byte lane enables widened to a bit mask
  function automatic logic [31:0] lane_mask(input logic [3:0] sel);
    lane_mask = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
  endfunction

  // Ring pointer step over the configured number of banks
  function automatic logic [1:0] ptr_step(input logic [1:0] p, input logic [1:0] n);
    ptr_step = (p + 2'h1 >= n) ? 2'h0 : p + 2'h1;
  endfunction

  // Bank count from software, clamped to what the pipe holds
  function automatic logic [1:0] clamp_nbank(input logic [1:0] v);
    if (v == 2'h0)
      clamp_nbank = 2'h1;
    else if (v > MAXB)
      clamp_nbank = MAXB;
    else
      clamp_nbank = v;
  endfunction

  // ==========================================================================
  // Next state
  always_comb
  begin
    next_s = s;
    // A request is taken only while ack is low, so a held strobe is served once
    hit = wb_cyc_i & wb_stb_i & ~s.ack;
    wr = hit & wb_we_i;
    wdat = wb_dat_i & lane_mask(wb_sel_i);
    cfg_wr = wr && wb_adr_i == uhpbs_pkg::OFS_CONFIG;
    dis_wr = wr && wb_adr_i == uhpbs_pkg::OFS_DISABLE;
    // One-cycle answer; unmapped reads return zero, writes are dropped
    next_s.ack = hit;
    next_s.dat = uhpbs_pkg::RD_ZERO;
    if (hit && !wb_we_i)
    begin
      case (wb_adr_i)
        uhpbs_pkg::OFS_STATUS:
        begin
          next_s.dat[uhpbs_pkg::ACCESS_BIT] = s.acc_ok;
          next_s.dat[uhpbs_pkg::CUR_BANK_LSB +: 2] = s.cur_bank;
          next_s.dat[uhpbs_pkg::BUSY_LSB +: 2] = s.busy;
          next_s.dat[uhpbs_pkg::TOGGLE_LSB +: 2] = s.toggle;
          next_s.dat[uhpbs_pkg::EV_W - 1:0] = s.status;
        end
        uhpbs_pkg::OFS_MASK:
          next_s.dat[uhpbs_pkg::EV_W - 1:0] = s.mask;
        uhpbs_pkg::OFS_CONFIG:
        begin
          next_s.dat[uhpbs_pkg::CFG_DIR_BIT] = s.dir_in;
          next_s.dat[uhpbs_pkg::CFG_NBANK_LSB +: 2] = s.nbank;
        end
        default:
          next_s.dat = uhpbs_pkg::RD_ZERO;
      endcase
    end
    // Bank handshakes; a handshake that would over- or underrun is dropped
    if (s.dir_in)
    begin
      us_ok = usb_bank_done_i && s.busy < s.nbank;
      sw_ok = sw_bank_done_i && s.busy != 2'h0;
    end
    else
    begin
      sw_ok = sw_bank_done_i && s.busy < s.nbank;
      us_ok = usb_bank_done_i && s.busy != 2'h0;
    end
    fill = s.dir_in ? us_ok : sw_ok;
    drain = s.dir_in ? sw_ok : us_ok;
    next_s.busy = s.busy + {1'b0, fill} - {1'b0, drain};
    if (sw_ok)
      next_s.sw_ptr = ptr_step(s.sw_ptr, s.nbank);
    if (us_ok)
      next_s.usb_ptr = ptr_step(s.usb_ptr, s.nbank);
    // OUT toggles after each packet sent; IN keeps each bank's received PID
    if (us_ok && !s.dir_in)
      next_s.out_tog = ~s.out_tog;
    if (us_ok && s.dir_in)
      next_s.bank_tog[s.usb_ptr] = rx_toggle_i;
    // Events; a set in the same cycle as its clear wins
    ev_set = 8'h00;
    ev_set[uhpbs_pkg::EV_IN_RX] = us_ok & s.dir_in;
    ev_set[uhpbs_pkg::EV_OUT_TX] = us_ok & ~s.dir_in;
    ev_set[uhpbs_pkg::EV_UNDER] = underflow_i;
    ev_set[uhpbs_pkg::EV_PERR] = pipe_err_i;
    ev_set[uhpbs_pkg::EV_NAK] = naked_i;
    ev_set[uhpbs_pkg::EV_OVER] = overflow_i;
    ev_set[uhpbs_pkg::EV_STALL] = rx_stall_i;
    ev_set[uhpbs_pkg::EV_BUSY] = s.dir_in
      ? (next_s.busy == 2'h0 && s.busy != 2'h0)
      : (next_s.busy == s.nbank && s.busy != s.nbank);
    ev_clr = 8'h00;
    if (wr && wb_adr_i == uhpbs_pkg::OFS_STATUS)
      ev_clr = wdat[uhpbs_pkg::EV_W - 1:0];
    next_s.status = (s.status & ~ev_clr) | ev_set;
    // Mask: direct write, or clear-by-one through the disable register
    // Mask bits live in byte lane 0; other lanes carry nothing here
    if (wr && wb_adr_i == uhpbs_pkg::OFS_MASK && wb_sel_i[0])
      next_s.mask = wb_dat_i[uhpbs_pkg::EV_W - 1:0];
    if (dis_wr)
      next_s.mask = s.mask & ~wdat[uhpbs_pkg::EV_W - 1:0];
    // Reconfiguring the pipe restarts its bank bookkeeping
    if (cfg_wr)
    begin
      if (wb_sel_i[0])
      begin
        next_s.dir_in = wb_dat_i[uhpbs_pkg::CFG_DIR_BIT];
        next_s.nbank = clamp_nbank(wb_dat_i[uhpbs_pkg::CFG_NBANK_LSB +: 2]);
      end
      next_s.busy = 2'h0;
      next_s.sw_ptr = 2'h0;
      next_s.usb_ptr = 2'h0;
      next_s.out_tog = 1'b0;
      next_s.bank_tog = 3'h0;
    end
    // Access flag follows the bank state; the bank index lags it one cycle
    if (next_s.dir_in)
      next_s.acc_ok = next_s.busy != 2'h0;
    else
      next_s.acc_ok = next_s.busy < next_s.nbank;
    if (next_s.status[uhpbs_pkg::EV_STALL] || next_s.status[uhpbs_pkg::EV_PERR])
      next_s.acc_ok = 1'b0;
    next_s.cur_bank = s.sw_ptr;
    // Bit 1 of the toggle field stays zero: only DATA0 and DATA1 exist
    next_s.toggle = {1'b0, next_s.dir_in ? next_s.bank_tog[next_s.sw_ptr]
                                         : next_s.out_tog};
    next_s.irq = |(next_s.status & next_s.mask);
  end

  // ==========================================================================
  // State register
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      // An OUT pipe with every bank free, so software may fill at once
      s <= '0;
      s.mask <= uhpbs_pkg::MASK_RST;
      s.nbank <= clamp_nbank(uhpbs_pkg::NBANK_RST);
      s.acc_ok <= 1'b1;
      s.toggle <= uhpbs_pkg::TOG_DATA0;
    end
    else
      s <= next_s;
  end

  // Outputs straight from flip-flops
  assign wb_ack_o = s.ack;
  assign wb_dat_o = s.dat;
  assign pipe_interrupt_line_o = s.irq;
  assign bank_access_allowed_o = s.acc_ok;
  assign current_bank_index_o = s.cur_bank;
  assign busy_bank_count_o = s.busy;
  assign data_toggle_field_o = s.toggle;

  // ==========================================================================
  // Checks
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  // Last free OUT bank filled by software
  sequence out_last_fill;
    !s.dir_in && sw_ok && !us_ok && s.busy + 2'h1 == s.nbank && !wr;
  endsequence

  // Last busy IN bank released by software
  sequence in_last_free;
    s.dir_in && sw_ok && !us_ok && s.busy == 2'h1 && !wr;
  endsequence

  bank_code_a: assert property (current_bank_index_o != uhpbs_pkg::BANK_RSVD)
    else $error("current bank shows reserved code");

  busy_range_a: assert property (s.busy <= s.nbank)
    else $error("busy count exceeds bank count");

  out_full_irq_a: assert property (out_last_fill and s.mask[uhpbs_pkg::EV_BUSY]
    |=> busy_bank_count_o == s.nbank && pipe_interrupt_line_o)
    else $error("all-busy OUT pipe did not interrupt");

  in_free_irq_a: assert property (in_last_free and s.mask[uhpbs_pkg::EV_BUSY]
    |=> busy_bank_count_o == 2'h0 && pipe_interrupt_line_o
    ##1 (pipe_interrupt_line_o || $past(wr)))
    else $error("all-free IN pipe did not interrupt");

  out_toggle_a: assert property (!s.dir_in && us_ok && !cfg_wr
    |=> data_toggle_field_o[0] == ~$past(s.out_tog))
    else $error("OUT toggle did not advance");

  in_toggle_a: assert property (s.dir_in |-> data_toggle_field_o[0] == s.bank_tog[s.sw_ptr])
    else $error("IN toggle differs from current bank");

  toggle_code_a: assert property (data_toggle_field_o[1] == 1'b0)
    else $error("toggle field shows reserved code");

  disable_clr_a: assert property (dis_wr |=> (s.mask & $past(wdat[7:0])) == 8'h00
    && pipe_interrupt_line_o == |(s.status & s.mask))
    else $error("disable write left mask bit set");

  stall_access_a: assert property ((rx_stall_i || pipe_err_i) |=> !bank_access_allowed_o)
    else $error("access flag set after stall or error");

  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");

  // ==========================================================================
  // Bank, access, mask and event checks
  // Received IN packet lands in the bank that the USB side just filled
  sequence in_capture;
    s.dir_in && us_ok && !cfg_wr;
  endsequence

  // A write of zeros to the disable register must not touch the mask
  sequence dis_zero;
    dis_wr && wdat[uhpbs_pkg::EV_W - 1:0] == 8'h00;
  endsequence

  // The stored PID is what the current bank will show once software reaches it
  in_capture_a: assert property (in_capture
    |=> s.bank_tog[$past(s.usb_ptr)] == $past(rx_toggle_i))
    else $error("IN toggle not stored in its bank");

  dis_zero_a: assert property (dis_zero |=> s.mask == $past(s.mask))
    else $error("zero disable write changed mask");

  // The line is a level: it may not outlive the last unmasked status bit
  irq_level_a: assert property (pipe_interrupt_line_o == |(s.status & s.mask))
    else $error("interrupt line differs from masked status");

  // A pending stall or error keeps software away from the bank
  access_clear_a: assert property (bank_access_allowed_o
    |-> !s.status[uhpbs_pkg::EV_STALL] && !s.status[uhpbs_pkg::EV_PERR])
    else $error("access flag set with stall or error pending");

  // Without stall or error the flag tracks bank fill for the pipe direction
  access_fill_a: assert property (s.status[uhpbs_pkg::EV_STALL] == 1'b0
    && s.status[uhpbs_pkg::EV_PERR] == 1'b0
    |-> bank_access_allowed_o == (s.dir_in ? s.busy != 2'h0 : s.busy < s.nbank))
    else $error("access flag does not follow bank fill");

  // The bank index trails the software pointer by exactly one cycle
  bank_lag_a: assert property (1'b1 |=> current_bank_index_o == $past(s.sw_ptr))
    else $error("bank index does not trail pointer");

  // An event pulse always reaches its sticky bit, even against a clear
  event_set_a: assert property (overflow_i |=> s.status[uhpbs_pkg::EV_OVER])
    else $error("overflow event lost");

  // Busy count moves by at most one bank per cycle outside a reconfiguration
  busy_step_a: assert property (!cfg_wr |=> busy_bank_count_o == $past(s.busy)
    || busy_bank_count_o == $past(s.busy) + 2'h1 || busy_bank_count_o == $past(s.busy) - 2'h1)
    else $error("busy count jumped");

endmodule

/* tb/tb_top.sv */
// Self-checking bench of the host pipe bank status block.
// Assumes a classic Wishbone master on clk_i and a model USB device.
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic go = 1'b0, tg = 1'b0, ack, irq, acc, udone, utog;
  logic [7:0] adr = 8'h00, evp = 8'h00, msk = 8'h00;
  logic [3:0] wt = 4'h0;
  logic [31:0] wdat = 32'h0000_0000, rdat, q;
  logic [1:0] bank, busy, tog;
  logic togs [3];
  int n_mismatch = 0, n_compared = 0, cyc_n = 0, ev = 0;
  // ==========================================================================
  // Clock, design and far-side device
  always #10 clk_i = ~clk_i;
  // Spare event slot 0 carries software bank done; slot 6 is the stall's own bit
  uhpbs_top DUT (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .sw_bank_done_i(evp[0]), .usb_bank_done_i(udone),
    .rx_toggle_i(utog), .rx_stall_i(evp[uhpbs_pkg::EV_STALL]),
    .overflow_i(evp[uhpbs_pkg::EV_OVER]), .naked_i(evp[uhpbs_pkg::EV_NAK]),
    .pipe_err_i(evp[uhpbs_pkg::EV_PERR]), .underflow_i(evp[uhpbs_pkg::EV_UNDER]),
    .pipe_interrupt_line_o(irq), .bank_access_allowed_o(acc),
    .current_bank_index_o(bank), .busy_bank_count_o(busy), .data_toggle_field_o(tog)
  );
  uhpbs_usb_dev dev (
    .clk_i(clk_i), .rst_i(rst_i), .go_i(go), .tog_i(tg), .wait_i(wt),
    .done_o(udone), .tog_o(utog)
  );
  // ==========================================================================
  // Checking, bus, event and device tasks
  task automatic final_report;
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Expected status word from its fields
  function automatic logic [31:0] st(logic a, logic [1:0] b, logic [1:0] n,
                                     logic [1:0] t, logic [7:0] e);
    return {15'h0000, a, b, n, 2'h0, t, e};
  endfunction
  // Classic single cycle: request held until ack is seen at a rising edge,
  // read data taken at that edge, then released; the next call idles a cycle
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n = 0;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    @(posedge clk_i);
    while (ack !== 1'b1 && n < 20)
    begin
      @(posedge clk_i);
      n++;
    end
    if (n >= 20)
    begin
      n_mismatch++;
      final_report();
    end
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask
  // One-cycle event; waits until the lagging bank index has settled
  task automatic pulse(input int i);
    @(posedge clk_i);
    evp[i] <= 1'b1;
    @(posedge clk_i);
    evp[i] <= 1'b0;
    repeat (2) @(negedge clk_i);
  endtask
  task automatic xfer(input logic t, input logic [3:0] w);
    int n = 0;
    @(posedge clk_i);
    go <= 1'b1;
    tg <= t;
    wt <= w;
    @(posedge clk_i);
    go <= 1'b0;
    while (udone !== 1'b1 && n < 40)
    begin
      @(negedge clk_i);
      n++;
    end
    if (n >= 40)
    begin
      n_mismatch++;
      final_report();
    end
    repeat (2) @(negedge clk_i);
  endtask
  // Hang guard, far above the few hundred cycles the run needs
  always @(posedge clk_i)
  begin
    cyc_n++;
    if (cyc_n > 4000)
    begin
      n_mismatch++;
      final_report();
    end
  end
  // ==========================================================================
  // Scenarios
  initial
  begin
    void'($urandom(32'h4256));
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(1'b0, uhpbs_pkg::OFS_STATUS, 32'h0000_0000);
    chk("status", st(1'b1, 2'h0, 2'h0, 2'h0, 8'h00), q);
    wb(1'b0, 8'hFC, 32'h0000_0000);
    chk("unmapped", 32'h0000_0000, q);
    $display("test reset done");
    wb(1'b1, uhpbs_pkg::OFS_MASK, 32'h0000_0082);
    for (int k = 1; k <= 4; k++)
    begin
      pulse(0);
      chk("busy", (k > 3) ? 3 : k, busy);
      chk("bank", ((k > 3) ? 3 : k) % 3, bank);
    end
    chk("irq", 32'h1, irq);
    chk("access", 32'h0, acc);
    xfer(1'($urandom), 4'h0);
    chk("toggle", 32'h1, tog);
    wb(1'b0, uhpbs_pkg::OFS_STATUS, 32'h0000_0000);
    chk("status", st(1'b1, 2'h0, 2'h2, 2'h1, 8'h82), q);
    $display("test out fill done");
    // Disable register: ones clear mask bits, zeros leave them alone
    wb(1'b1, uhpbs_pkg::OFS_DISABLE, 32'h0000_0080);
    chk("irq", 32'h1, irq);
    wb(1'b1, uhpbs_pkg::OFS_DISABLE, 32'h0000_0000);
    wb(1'b0, uhpbs_pkg::OFS_MASK, 32'h0000_0000);
    chk("mask", 32'h0000_0002, q);
    wb(1'b1, uhpbs_pkg::OFS_DISABLE, 32'h0000_0002);
    chk("irq", 32'h0, irq);
    wb(1'b1, uhpbs_pkg::OFS_STATUS, 32'h0000_00FF);
    wb(1'b0, uhpbs_pkg::OFS_STATUS, 32'h0000_0000);
    chk("status", st(1'b1, 2'h0, 2'h2, 2'h1, 8'h00), q);
    $display("test disable done");
    // Random event sources under a random mask; error and stall block access
    for (int k = 0; k < 8; k++)
    begin
      ev = 2 + int'($urandom % 5);
      msk = 8'($urandom);
      wb(1'b1, uhpbs_pkg::OFS_MASK, {24'h00_0000, msk});
      pulse(ev);
      chk("irq", msk[ev], irq);
      chk("access", (ev == uhpbs_pkg::EV_PERR || ev == uhpbs_pkg::EV_STALL) ? 0 : 1, acc);
      wb(1'b0, uhpbs_pkg::OFS_STATUS, 32'h0000_0000);
      chk("events", 8'h01 << ev, q[7:0]);
      wb(1'b1, uhpbs_pkg::OFS_STATUS, 32'h0000_00FF);
    end
    $display("test events done");
    // IN pipe with three banks: the device fills, software frees
    wb(1'b1, uhpbs_pkg::OFS_CONFIG, 32'h0000_0031);
    wb(1'b1, uhpbs_pkg::OFS_MASK, 32'h0000_0080);
    for (int k = 0; k < 3; k++)
    begin
      togs[k] = 1'($urandom);
      xfer(togs[k], 4'($urandom));
      chk("busy", k + 1, busy);
      chk("toggle", togs[0], tog);
    end
    chk("irq", 32'h0, irq);
    chk("access", 32'h1, acc);
    for (int k = 1; k <= 3; k++)
    begin
      pulse(0);
      chk("busy", 3 - k, busy);
      chk("bank", k % 3, bank);
      chk("toggle", togs[k % 3], tog);
    end
    chk("irq", 32'h1, irq);
    chk("access", 32'h0, acc);
    $display("test in drain done");
    final_report();
  end
endmodule

/* tb/uhpbs_usb_dev.sv */
// Behavioural USB device that answers the host pipe, one bank at a time.
// Assumes the bench asks for one transfer at a time, on clk_i.
module uhpbs_usb_dev (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic go_i,
  input wire logic tog_i,
  input wire logic [3:0] wait_i,
  output logic done_o,
  output logic tog_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic busy;
  logic hold;
  logic [3:0] cnt;
  // ==========================================================================
  // Bank transfer
  // Delay is chosen per transfer, so both prompt and slow answers occur.
  // The toggle line is only valid with done; once released it shows the
  // inverse of its last value, so a late sample by the pipe cannot pass.
  always_ff @(posedge clk_i)
  begin
    done_o <= 1'b0;
    if (done_o)
      tog_o <= ~tog_o;
    if (rst_i)
    begin
      busy <= 1'b0;
      tog_o <= 1'b0;
    end
    else if (go_i && !busy)
    begin
      busy <= 1'b1;
      cnt <= wait_i;
      hold <= tog_i;
    end
    else if (busy && cnt != 4'h0)
      cnt <= cnt - 4'h1;
    else if (busy)
    begin
      busy <= 1'b0;
      done_o <= 1'b1;
      tog_o <= hold;
    end
  end
endmodule
